// [verilog/usb_phy_iface_flags_regs.sv]
`timescale 1ns/100ps
module usb_phy_iface_flags_regs #(
   parameter int NUM_PORTS = 4
) (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire usb_iface_pkg::per_req_t    per_req,
   output logic [31:0]                     per_rdata,
   output logic                            per_ack,
   input  wire usb_iface_pkg::otg_status_t otg_pins,
   input  wire usb_iface_pkg::serial_rx_t  serial_pins,
   input  wire logic [1:0]                 linestate_pins,
   input  wire logic                       rx_active,
   input  wire logic                       rx_valid,
   input  wire logic                       rx_error,
   input  wire logic [7:0]                 rx_data,
   input  wire logic [6:0]                 dev_addr,
   output usb_iface_pkg::serial_tx_t       serial_tx,
   output logic [NUM_PORTS-1:0]            event_port,
   output logic [4:0]                      rx_ep_data,
   output logic                            rx_ep_strobe
);
   import usb_iface_pkg::*;

   if (NUM_PORTS < 3 || NUM_PORTS > 4) begin : g_bad_ports
      $error("NUM_PORTS must be 3 or 4");
   end

   function automatic logic [4:0] crc5_bits(input logic [4:0] c, input logic [15:0] d);
      logic [4:0] r;
      r = c;
      for (int i = 0; i < 16; i++) begin
         r = {r[3:0], 1'b0} ^ ((d[i] ^ r[4]) ? CRC5_POLY : 5'h00);
      end
      return r;
   endfunction

   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = {r[14:0], 1'b0} ^ ((d[i] ^ r[15]) ? CRC16_POLY : 16'h0000);
      end
      return r;
   endfunction

   // Write strobe for one register offset
   function automatic logic wr_hit(input per_req_t r, input logic [7:0] off);
      return r.wr && r.addr == off;
   endfunction

   // Two-flop synchronisers for transceiver levels
   // Line bits reset to SE1 so leaving reset raises no line flag
   logic [10:0] sync1_r;
   logic [10:0] sync2_r;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_r <= SYNC_RESET;
         sync2_r <= SYNC_RESET;
      end else begin
         sync1_r <= {otg_pins, serial_pins, linestate_pins};
         sync2_r <= sync1_r;
      end
   end
   wire otg_status_t otg_s   = sync2_r[10:5];
   wire serial_rx_t  serial_s = sync2_r[4:2];
   wire logic [1:0]  ls_s     = sync2_r[1:0];

   // Register bus decode
   wire logic wr_otg   = wr_hit(per_req, OFF_OTG_SESSION_STATUS);
   wire logic wr_ser   = wr_hit(per_req, OFF_SERIAL_LINE_CONTROL);
   wire logic wr_flags = wr_hit(per_req, OFF_LINE_EVENT_FLAGS);
   wire logic wr_stky  = wr_hit(per_req, OFF_EVENT_STICKINESS);
   wire logic wr_mask  = wr_hit(per_req, OFF_EVENT_PORT_MASKS);
   wire logic wr_sof   = wr_hit(per_req, OFF_FRAME_START_COUNTER);
   wire logic wr_mark  = wr_hit(per_req, OFF_ENDPOINT_SPECIAL_MARK);

   logic [3:0]        serial_ctrl_r;
   logic [FLAG_W-1:0] flags_r;
   logic [FLAG_W-1:0] sticky_r;
   logic [31:0]       masks_r;
   logic [10:0]       sof_count_r;
   logic [3:0]        last_pid_r;
   logic [4:0]        last_ep_r;
   logic [15:0]       ep_mark_r;

   // Packet parser
   parse_state_t ps_r;
   parse_state_t ps_nxt;
   logic         rx_active_d_r;
   logic [7:0]   tok1_r;
   logic [15:0]  crc16_r;
   logic [3:0]   cur_pid_r;

   wire logic pkt_start = rx_active && !rx_active_d_r;
   wire logic pkt_end   = !rx_active && rx_active_d_r;
   wire logic byte_ev   = rx_active && rx_valid;
   wire logic pid_ok    = rx_data[3:0] == ~rx_data[7:4];
   wire logic pid_token = rx_data[3:0] == PID_OUT || rx_data[3:0] == PID_IN ||
                          rx_data[3:0] == PID_SETUP || rx_data[3:0] == PID_SOF;
   wire logic pid_data  = rx_data[1:0] == 2'b11;
   wire logic tok_last  = ps_r == PS_TOK2 && byte_ev;
   wire logic crc5_ok   = crc5_bits(CRC5_INIT, {rx_data, tok1_r}) == CRC5_RESIDUAL;
   wire logic [3:0] tok_ep = {rx_data[2:0], tok1_r[7]};
   wire logic is_sof    = cur_pid_r == PID_SOF;
   wire logic tok_ok    = tok_last && crc5_ok && !is_sof && tok1_r[6:0] == dev_addr;
   wire logic sof_ok    = tok_last && crc5_ok && is_sof;
   wire logic crc16_bad = pkt_end && ps_r == PS_DATA && crc16_r != CRC16_RESIDUAL;

   always_comb begin
      ps_nxt = ps_r;
      unique case (ps_r)
         PS_IDLE: if (byte_ev) begin
            ps_nxt = !pid_ok ? PS_SKIP : pid_token ? PS_TOK1 : pid_data ? PS_DATA : PS_SKIP;
         end
         PS_TOK1: if (byte_ev) begin
            ps_nxt = PS_TOK2;
         end
         PS_TOK2: if (byte_ev) begin
            ps_nxt = PS_SKIP;
         end
         PS_DATA: ps_nxt = PS_DATA;
         PS_SKIP: ps_nxt = PS_SKIP;
      endcase
      if (!rx_active) begin
         ps_nxt = PS_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ps_r          <= PS_IDLE;
         rx_active_d_r <= 1'b0;
         tok1_r        <= 8'h00;
         crc16_r       <= CRC16_INIT;
         cur_pid_r     <= 4'h0;
      end else begin
         ps_r          <= ps_nxt;
         rx_active_d_r <= rx_active;
         if (ps_r == PS_TOK1 && byte_ev) begin
            tok1_r <= rx_data;
         end
         if (ps_r == PS_IDLE && byte_ev) begin
            cur_pid_r <= rx_data[3:0];
            crc16_r   <= CRC16_INIT;
         end else if (ps_r == PS_DATA && byte_ev) begin
            crc16_r <= crc16_byte(crc16_r, rx_data);
         end
      end
   end

   // Event sources
   logic [FLAG_W-1:0] flag_ev;
   assign flag_ev[token_decoded_flag]  = tok_ok;
   assign flag_ev[se0_seen_flag]       = ls_s == LS_SE0;
   assign flag_ev[k_seen_flag]         = ls_s == LS_K;
   assign flag_ev[j_seen_flag]         = ls_s == LS_J;
   assign flag_ev[crc16_fail_flag]     = crc16_bad;
   assign flag_ev[receive_active_flag] = rx_active;
   assign flag_ev[receive_error_flag]  = rx_error;

   // Set wins over a software clear in the same cycle
   wire logic [FLAG_W-1:0] flag_clr  = wr_flags ? per_req.wdata[FLAG_W-1:0] : '0;
   wire logic [FLAG_W-1:0] flag_keep = sticky_r | (~FOLLOW_FLAGS & ~{FLAG_W{pkt_start}});
   wire logic [FLAG_W-1:0] flags_nxt = flag_ev | (flags_r & flag_keep & ~flag_clr);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_r  <= FLAGS_RESET;
         sticky_r <= '0;
         masks_r  <= 32'h0000_0000;
      end else begin
         flags_r <= flags_nxt;
         if (wr_stky) begin
            sticky_r <= per_req.wdata[FLAG_W-1:0];
         end
         if (wr_mask) begin
            masks_r <= per_req.wdata;
         end
      end
   end

   // Signalling ports; mask bit 7 selects no flag
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign event_port[p] = |(flags_r & masks_r[p*8 +: FLAG_W]);
   end

   // Serial control, frame counter, capture registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         serial_ctrl_r <= SERIAL_CTRL_RESET;
         sof_count_r   <= 11'h000;
         last_pid_r    <= 4'h0;
         last_ep_r     <= 5'h00;
         ep_mark_r     <= 16'h0000;
         rx_ep_data    <= 5'h00;
         rx_ep_strobe  <= 1'b0;
      end else begin
         if (wr_ser) begin
            serial_ctrl_r <= per_req.wdata[3:0];
         end
         if (sof_ok) begin
            sof_count_r <= {rx_data[2:0], tok1_r};
         end else if (wr_sof) begin
            sof_count_r <= per_req.wdata[10:0];
         end
         if (ps_r == PS_IDLE && byte_ev && pid_ok) begin
            last_pid_r <= rx_data[3:0];
         end
         if (tok_ok) begin
            last_ep_r <= {1'b1, tok_ep};
         end
         if (wr_mark) begin
            ep_mark_r <= per_req.wdata[15:0];
         end
         rx_ep_strobe <= tok_ok;
         if (tok_ok) begin
            rx_ep_data <= {1'b0, tok_ep} | (ep_mark_r[tok_ep] ? SPECIAL_EP_OR : 5'h00);
         end
      end
   end

   assign serial_tx.se0         = serial_ctrl_r[serial_tx_single_ended_zero];
   assign serial_tx.data        = serial_ctrl_r[serial_tx_data_bit];
   assign serial_tx.enable_n    = serial_ctrl_r[serial_tx_enable_low];
   assign serial_tx.fsls_serial = serial_ctrl_r[full_low_speed_serial_select];

   // Read words; reserved bits and unmapped offsets read zero
   wire logic [31:0] rw_otg   = {26'h0, otg_s};
   wire logic [31:0] rw_ser   = {25'h0, serial_s, serial_ctrl_r};
   wire logic [31:0] rw_flags = {25'h0, flags_r};
   wire logic [31:0] rw_stky  = {25'h0, sticky_r};
   wire logic [31:0] rw_sof   = {21'h0, sof_count_r};
   wire logic [31:0] rw_pid   = {28'h0, last_pid_r};
   wire logic [31:0] rw_ep    = {27'h0, last_ep_r};
   wire logic [31:0] rw_mark  = {16'h0, ep_mark_r};
   wire logic [7:0]  rd_addr  = per_req.addr;
   wire logic [31:0] rd_mux   =
      rd_addr == OFF_OTG_SESSION_STATUS    ? rw_otg   :
      rd_addr == OFF_SERIAL_LINE_CONTROL   ? rw_ser   :
      rd_addr == OFF_LINE_EVENT_FLAGS      ? rw_flags :
      rd_addr == OFF_EVENT_STICKINESS      ? rw_stky  :
      rd_addr == OFF_EVENT_PORT_MASKS      ? masks_r  :
      rd_addr == OFF_FRAME_START_COUNTER   ? rw_sof   :
      rd_addr == OFF_LAST_PACKET_IDENT     ? rw_pid   :
      rd_addr == OFF_LAST_ENDPOINT         ? rw_ep    :
      rd_addr == OFF_ENDPOINT_SPECIAL_MARK ? rw_mark  : 32'h0000_0000;

   // Whole-word access only; no byte lanes exist
   always_ff @(posedge clk) begin
      if (!resetn) begin
         per_rdata <= 32'h0000_0000;
         per_ack   <= 1'b0;
      end else begin
         per_ack <= per_req.wr || per_req.rd;
         if (per_req.rd) begin
            per_rdata <= rd_mux;
         end
      end
   end

   // Status register is read-only; writes to it are dropped
   wire logic unused_wr = wr_otg;

endmodule

// [verilog/usb_iface_pkg.sv]
package usb_iface_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_OTG_SESSION_STATUS    = 8'h14;
   localparam logic [7:0] OFF_SERIAL_LINE_CONTROL   = 8'h18;
   localparam logic [7:0] OFF_LINE_EVENT_FLAGS      = 8'h1C;
   localparam logic [7:0] OFF_EVENT_STICKINESS      = 8'h20;
   localparam logic [7:0] OFF_EVENT_PORT_MASKS      = 8'h24;
   localparam logic [7:0] OFF_FRAME_START_COUNTER   = 8'h28;
   localparam logic [7:0] OFF_LAST_PACKET_IDENT     = 8'h2C;
   localparam logic [7:0] OFF_LAST_ENDPOINT         = 8'h30;
   localparam logic [7:0] OFF_ENDPOINT_SPECIAL_MARK = 8'h34;

   // Serial control field positions
   localparam int serial_diff_receive_bit      = 6;
   localparam int serial_dminus_receive_bit    = 5;
   localparam int serial_dplus_receive_bit     = 4;
   localparam int serial_tx_single_ended_zero  = 3;
   localparam int serial_tx_data_bit           = 2;
   localparam int serial_tx_enable_low         = 1;
   localparam int full_low_speed_serial_select = 0;
   localparam logic [3:0] SERIAL_CTRL_RESET    = 4'h2;

   // Event flag positions
   localparam int token_decoded_flag = 6;
   localparam int se0_seen_flag      = 5;
   localparam int k_seen_flag        = 4;
   localparam int j_seen_flag        = 3;
   localparam int crc16_fail_flag    = 2;
   localparam int receive_active_flag = 1;
   localparam int receive_error_flag = 0;
   localparam int FLAG_W             = 7;
   localparam logic [6:0] FOLLOW_FLAGS = 7'h03;
   localparam logic [6:0] FLAGS_RESET  = 7'h00;

   // Field positions of frame counter, endpoint
   localparam int frame_count_high = 8;
   localparam int frame_count_low  = 0;
   localparam int ENDPOINT_VALID_BIT = 4;
   localparam logic [4:0] SPECIAL_EP_OR = 5'h10;

   // Line states and packet identifiers
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J   = 2'h1;
   localparam logic [1:0] LS_K   = 2'h2;
   localparam logic [10:0] SYNC_RESET = 11'h003;
   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_SOF   = 4'h5;
   localparam logic [4:0]  CRC5_INIT     = 5'h1F;
   localparam logic [4:0]  CRC5_POLY     = 5'h05;
   localparam logic [4:0]  CRC5_RESIDUAL = 5'h0C;
   localparam logic [15:0] CRC16_INIT     = 16'hFFFF;
   localparam logic [15:0] CRC16_POLY     = 16'h8005;
   localparam logic [15:0] CRC16_RESIDUAL = 16'h800D;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } per_req_t;

   typedef struct packed {
      logic b_session_valid;
      logic id_ground;
      logic host_disconnect;
      logic vbus_valid;
      logic session_valid;
      logic session_end;
   } otg_status_t;

   typedef struct packed {
      logic diff_rx;
      logic dminus_rx;
      logic dplus_rx;
   } serial_rx_t;

   typedef struct packed {
      logic se0;
      logic data;
      logic enable_n;
      logic fsls_serial;
   } serial_tx_t;

   typedef enum logic [2:0] {
      PS_IDLE, PS_TOK1, PS_TOK2, PS_DATA, PS_SKIP
   } parse_state_t;

endpackage

// [testbench/usb_phy_iface_flags_regs_properties.sv]
`timescale 1ns/100ps
module usb_phy_iface_flags_regs_properties #(
   parameter int NUM_PORTS = 4
) (
   input wire logic                    clk,
   input wire logic                    resetn,
   input wire usb_iface_pkg::per_req_t per_req,
   input wire logic [31:0]             per_rdata,
   input wire logic                    per_ack,
   input wire logic                    rx_active,
   input wire logic                    rx_valid,
   input wire usb_iface_pkg::serial_tx_t serial_tx,
   input wire logic [NUM_PORTS-1:0]    event_port,
   input wire logic [4:0]              rx_ep_data,
   input wire logic                    rx_ep_strobe
);
   import usb_iface_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   ack_after_req_a: assert property ((per_req.wr || per_req.rd) |=> per_ack)
      else $error("request without acknowledge");
   ack_cause_a: assert property (per_ack |-> $past(per_req.wr || per_req.rd))
      else $error("acknowledge without request");
   rdata_hold_a: assert property (!per_ack |-> $stable(per_rdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property ((per_req.rd && (per_req.addr[1:0] != 2'h0
      || per_req.addr < 8'h14 || per_req.addr > 8'h34)) |=> per_rdata == 32'h0)
      else $error("unmapped read not zero");
   serial_write_a: assert property ((per_req.wr
      && per_req.addr == OFF_SERIAL_LINE_CONTROL) |=> serial_tx == $past(per_req.wdata[3:0]))
      else $error("serial outputs not loaded by write");
   serial_reset_a: assert property ($rose(resetn)
      |-> serial_tx == 4'h2 && rx_ep_data == 5'h00)
      else $error("wrong outputs after reset");
   strobe_pulse_a: assert property (rx_ep_strobe |=> !rx_ep_strobe)
      else $error("endpoint strobe longer than a cycle");
   strobe_cause_a: assert property (rx_ep_strobe |-> $past(rx_active && rx_valid))
      else $error("endpoint strobe without a received byte");
   pid_reserved_a: assert property ((per_req.rd
      && per_req.addr == OFF_LAST_PACKET_IDENT) |=> per_rdata[31:4] == 28'h0)
      else $error("packet ident reserved bits set");
   mask_clear_a: assert property ((per_req.wr && per_req.addr == OFF_EVENT_PORT_MASKS
      && per_req.wdata == 32'h0) |=> event_port == '0)
      else $error("event port high with empty masks");
endmodule
bind usb_phy_iface_flags_regs usb_phy_iface_flags_regs_properties #(.NUM_PORTS(NUM_PORTS)) i_props (
   .clk(clk), .resetn(resetn), .per_req(per_req), .per_rdata(per_rdata), .per_ack(per_ack),
   .rx_active(rx_active), .rx_valid(rx_valid), .serial_tx(serial_tx), .event_port(event_port),
   .rx_ep_data(rx_ep_data), .rx_ep_strobe(rx_ep_strobe));

// [testbench/utmi_phy_model.sv]
`timescale 1ns/100ps
module utmi_phy_model (
   input  wire logic                  clk,
   output usb_iface_pkg::otg_status_t otg_pins,
   output usb_iface_pkg::serial_rx_t  serial_pins,
   output logic [1:0]                 linestate_pins,
   output logic                       rx_active,
   output logic                       rx_valid,
   output logic                       rx_error,
   output logic [7:0]                 rx_data
);
   import usb_iface_pkg::*;
   // Line starts in SE1 so no line flag is raised before the first check
   initial begin
      otg_pins = '0;
      serial_pins = '0;
      linestate_pins = 2'h3;
      {rx_active, rx_valid, rx_error} = 3'h0;
      rx_data = 8'h00;
   end
   task automatic pins(input logic [5:0] o, input logic [2:0] s, input logic [1:0] l);
      @(negedge clk);
      otg_pins = o;
      serial_pins = s;
      linestate_pins = l;
   endtask
   task automatic err_pulse;
      @(negedge clk);
      rx_error = 1'b1;
      @(negedge clk);
      rx_error = 1'b0;
   endtask
   // Idle data is inverted so a stale byte never looks valid
   task automatic send(input logic [7:0] b[$], input bit slow);
      @(negedge clk);
      rx_active = 1'b1;
      foreach (b[i]) begin
         if (slow) begin
            @(negedge clk);
            rx_valid = 1'b0;
            rx_data = ~rx_data;
         end
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = b[i];
      end
      @(negedge clk);
      {rx_active, rx_valid} = 2'h0;
      rx_data = ~rx_data;
      repeat (2) @(negedge clk);
   endtask
   function automatic logic [4:0] crc5(input logic [10:0] v);
      logic [4:0] c;
      logic       fb;
      c = 5'h1F;
      for (int i = 0; i < 11; i++) begin
         fb = v[i] ^ c[4];
         c = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
      end
      return {~c[0], ~c[1], ~c[2], ~c[3], ~c[4]};
   endfunction
   task automatic token(input logic [3:0] pid, input logic [10:0] v, input bit bad, input bit slow);
      logic [7:0] q[$];
      q.push_back({~pid, pid});
      q.push_back(v[7:0]);
      q.push_back({crc5(v) ^ {4'h0, bad}, v[10:8]});
      send(q, slow);
   endtask
endmodule

// [testbench/usb_phy_iface_flags_regs_bench.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module usb_phy_iface_flags_regs_bench;
   import usb_iface_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   per_req_t    per_req = '0;
   logic [6:0]  dev_addr = 7'h00;
   logic [31:0] per_rdata;
   logic        per_ack, rx_active, rx_valid, rx_error, rx_ep_strobe;
   logic [7:0]  rx_data;
   logic [1:0]  linestate_pins;
   logic [3:0]  event_port;
   logic [4:0]  rx_ep_data;
   otg_status_t otg_pins;
   serial_rx_t  serial_pins;
   serial_tx_t  serial_tx;
   int          miscompares = 0;
   int          compares = 0;
   logic [7:0]  offs[11] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
                            8'h38, 8'h00};
   logic [7:0]  wa[7] = '{8'h20, 8'h24, 8'h28, 8'h34, 8'h14, 8'h2C, 8'h30};
   logic [31:0] we[7] = '{32'h7F, 32'hFFFFFFFF, 32'h7FF, 32'hFFFF, 32'h0, 32'h0, 32'h0};
   logic [1:0]  lsv[3] = '{LS_SE0, LS_K, LS_J};
   logic [3:0]  tpid[5] = '{PID_IN, PID_OUT, PID_OUT, PID_SETUP, PID_SOF};
   logic [10:0] tval[5] = '{11'h2BA, 11'h13B, 11'h13A, 11'h13A, 11'h5A3};
   bit          tbad[5] = '{0, 0, 1, 0, 0};
   bit          tf6[5] = '{1, 0, 0, 1, 0};
   logic [4:0]  tep[5] = '{5'h15, 5'h15, 5'h15, 5'h02, 5'h02};
   logic [7:0]  good_pkt[$] = '{8'hC3, 8'h00, 8'h00};
   logic [7:0]  bad_pkt[$] = '{8'hC3, 8'h01, 8'h00, 8'h00};
   always #50 clk = ~clk;
   usb_phy_iface_flags_regs #(.NUM_PORTS(4)) i_usb_phy_iface_flags_regs (
      .clk(clk), .resetn(resetn), .per_req(per_req), .per_rdata(per_rdata),
      .per_ack(per_ack), .otg_pins(otg_pins), .serial_pins(serial_pins),
      .linestate_pins(linestate_pins), .rx_active(rx_active), .rx_valid(rx_valid),
      .rx_error(rx_error), .rx_data(rx_data), .dev_addr(dev_addr), .serial_tx(serial_tx),
      .event_port(event_port), .rx_ep_data(rx_ep_data), .rx_ep_strobe(rx_ep_strobe));
   utmi_phy_model i_utmi_phy_model (
      .clk(clk), .otg_pins(otg_pins), .serial_pins(serial_pins),
      .linestate_pins(linestate_pins), .rx_active(rx_active), .rx_valid(rx_valid),
      .rx_error(rx_error), .rx_data(rx_data));
   task automatic wrap_up;
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Whole-word access only, one request per two cycles
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(negedge clk);
      per_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      per_req = '0;
      n = 0;
      while (per_ack !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (per_ack !== 1'b1) begin
         miscompares++;
         wrap_up();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, per_rdata)
   endtask
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      `CHK("serial_tx", 4'h2, serial_tx)
      foreach (offs[i]) begin
         rd(offs[i], offs[i] == 8'h18 ? 32'h2 : 32'h0);
      end
      foreach (wa[i]) begin
         bus(1'b1, wa[i], 32'hFFFFFFFF);
         rd(wa[i], we[i]);
      end
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h24, 32'h0);
      i_utmi_phy_model.pins(6'h2A, 3'b101, 2'h3);
      bus(1'b1, 8'h18, 32'hFFFFFFF9);
      repeat (3) @(negedge clk);
      `CHK("serial_tx", 4'h9, serial_tx)
      rd(8'h18, 32'h59);
      rd(8'h14, 32'h2A);
      bus(1'b1, 8'h24, 32'h40081020);
      foreach (lsv[i]) begin
         i_utmi_phy_model.pins(6'h2A, 3'b101, lsv[i]);
         repeat (4) @(negedge clk);
         bus(1'b1, 8'h1C, 32'h38);
         rd(8'h1C, 32'h1 << (5 - i));
         `CHK("event_port", 4'(1 << i), event_port)
      end
      i_utmi_phy_model.pins(6'h2A, 3'b101, 2'h3);
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, 8'h20, 32'(s << 2));
         bus(1'b1, 8'h1C, 32'h7F);
         i_utmi_phy_model.send(bad_pkt, 1'b0);
         rd(8'h1C, 32'h4);
         i_utmi_phy_model.send(good_pkt, 1'b1);
         rd(8'h1C, s ? 32'h4 : 32'h0);
      end
      bus(1'b1, 8'h20, 32'h1);
      i_utmi_phy_model.err_pulse();
      repeat (3) @(negedge clk);
      rd(8'h1C, 32'h5);
      bus(1'b1, 8'h1C, 32'h5);
      rd(8'h1C, 32'h0);
      bus(1'b1, 8'h20, 32'h0);
      i_utmi_phy_model.err_pulse();
      repeat (3) @(negedge clk);
      rd(8'h1C, 32'h0);
      dev_addr = 7'h3A;
      bus(1'b1, 8'h34, 32'h20);
      bus(1'b1, 8'h24, 32'h40000000);
      foreach (tpid[i]) begin
         i_utmi_phy_model.token(tpid[i], tval[i], tbad[i], i == 3);
         rd(8'h1C, tf6[i] ? 32'h40 : 32'h0);
         `CHK("rx_ep_data", tep[i], rx_ep_data)
         `CHK("event_port", {tf6[i], 3'h0}, event_port)
      end
      rd(8'h28, 32'h5A3);
      rd(8'h2C, 32'h5);
      rd(8'h30, 32'h12);
      wrap_up();
   end
endmodule
